// >>> design/rwc_pkg.sv
// constants and types shared by the reset, watchdog and wake-up control block
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port
package rwc_pkg;
  localparam int CLK_MHZ = 100;

  localparam int          ADDR_W         = 8;
  localparam logic [7:0]  ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0]  ADDR_WAKE_IN   = 8'h04;
  localparam logic [7:0]  ADDR_LOW_POWER = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0c;

  localparam int MCR_SAFE_BIT   = 0;
  localparam int WUR_PINS_LSB   = 0;
  localparam int WUR_SRC_LSB    = 4;
  localparam int WUR_SENS_LSB   = 8;
  localparam int LPC_AUTO_BIT   = 0;
  localparam int LPC_FWU_BIT    = 1;
  localparam int LPC_BIAS_BIT   = 3;
  localparam int STAT_RST_BIT   = 0;
  localparam int STAT_WDF_BIT   = 1;
  localparam int STAT_UV_BIT    = 2;

  localparam logic       SAFE_RST = 1'b0;
  localparam logic [1:0] SENS_RST = 2'h0;
  localparam logic [3:0] LPC_RST  = 4'h0;
  localparam logic [3:0] SRC_RST  = 4'h0;

  localparam logic [2:0] OP_NORMAL_REQ = 3'h0;
  localparam logic [2:0] OP_NORMAL     = 3'h1;
  localparam logic [2:0] OP_STANDBY    = 3'h2;
  localparam logic [2:0] OP_SLEEP      = 3'h3;
  localparam logic [2:0] OP_STOP       = 3'h4;
  localparam logic [2:0] OP_DBG_NORMAL = 3'h5;
  localparam logic [2:0] OP_DBG_STDBY  = 3'h6;
  localparam logic [2:0] OP_STOP_DBG   = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int RST_DUR_NS   = 3400000;
  localparam int RST_DUR_CYC  = (RST_DUR_NS * CLK_MHZ + 999) / 1000;
  localparam int INT_PULSE_NS = 10000;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_PERIOD_DEF = 5000000;
  localparam int CYC_ON_DEF     = 20000;

  typedef enum logic [1:0] {PH_IDLE, PH_RESET, PH_INT} phase_t;
endpackage

// >>> design/wake_if.sv
// signals between the control core and the wake-input sensing logic
// assumes both ends sit on the same aclk
`timescale 1ns/1ps
`default_nettype none
interface wake_if;
  logic [1:0] sens;
  logic       cyclic_en;
  logic       low_power;
  logic [3:0] pins;
  logic       wake;
  logic [3:0] src;
  logic       hs_on;
  modport ctrl  (output sens, cyclic_en, low_power, pins, input wake, src, hs_on);
  modport sense (input sens, cyclic_en, low_power, pins, output wake, src, hs_on);
endinterface
`default_nettype wire

// >>> design/wake_sense.sv
// wake input sensing: direct level wake or timer-driven cyclic sense
// assumes pins arrive already synchronised to aclk
`timescale 1ns/1ps
`default_nettype none
module wake_sense #(
  parameter int PERIOD_CYC = rwc_pkg::CYC_PERIOD_DEF,
  parameter int ON_CYC     = rwc_pkg::CYC_ON_DEF
) (
  input  wire logic aclk,    // clock
  input  wire logic aresetn, // sync reset, low
  wake_if.sense     w        // control side
);
  localparam int CW = $clog2(PERIOD_CYC + 1);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [3:0]    ref_r, ref_nxt;
  logic          have_ref_r, have_ref_nxt;
  logic          done_r, done_nxt;
  logic          wake_r, wake_nxt;
  logic [3:0]    src_r, src_nxt;
  logic          hs_r, hs_nxt;
  logic [3:0]    lvl_hit;
  logic          sample;

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_pin
      assign lvl_hit[i] = (w.pins[i] == w.sens[i/2]);
    end
  endgenerate

  assign sample = w.cyclic_en && (cnt_r == CW'(ON_CYC - 1));

  always_comb
  begin
    cnt_nxt      = '0;
    ref_nxt      = ref_r;
    have_ref_nxt = have_ref_r;
    done_nxt     = done_r;
    wake_nxt     = 1'b0;
    src_nxt      = src_r;
    hs_nxt       = 1'b0;
    if (!w.low_power)
    begin
      have_ref_nxt = 1'b0;
      done_nxt     = 1'b0;
    end
    else if (w.cyclic_en)
    begin
      cnt_nxt = (cnt_r == CW'(PERIOD_CYC - 1)) ? '0 : cnt_r + CW'(1);
      hs_nxt  = (cnt_nxt < CW'(ON_CYC));
      if (sample)
      begin
        ref_nxt      = w.pins;
        have_ref_nxt = 1'b1;
        if (have_ref_r && (w.pins != ref_r) && !done_r)
        begin
          wake_nxt = 1'b1;
          src_nxt  = w.pins ^ ref_r;
          done_nxt = 1'b1;
        end
      end
    end
    else if ((|lvl_hit) && !done_r)
    begin
      wake_nxt = 1'b1;
      src_nxt  = lvl_hit;
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r      <= '0;
      ref_r      <= 4'h0;
      have_ref_r <= 1'b0;
      done_r     <= 1'b0;
      wake_r     <= 1'b0;
      src_r      <= 4'h0;
      hs_r       <= 1'b0;
    end
    else
    begin
      cnt_r      <= cnt_nxt;
      ref_r      <= ref_nxt;
      have_ref_r <= have_ref_nxt;
      done_r     <= done_nxt;
      wake_r     <= wake_nxt;
      src_r      <= src_nxt;
      hs_r       <= hs_nxt;
    end
  end

  assign w.wake  = wake_r;
  assign w.src   = src_r;
  assign w.hs_on = hs_r;
endmodule
`default_nettype wire

// >>> design/reset_watchdog_wakeup_ctrl.sv
// reset, watchdog-fault and wake-up control with an AXI4-Lite register port
// assumes op_mode, wd_timeout and wd_serviced come from logic on aclk;
// main_reg_low and wake_inputs are asynchronous pins
//
// Behaviour
// - normal and safe output modes by safe bit; normal after reset
// - safe bit is independent of the operating mode
// - reset output asserted at power-up and at wake-up from sleep
// - normal mode: undervoltage or watchdog timeout asserts reset
// - watchdog-fault output low with reset, released when watchdog serviced
// - safe mode: watchdog fault leaves reset high, fault output still driven low
// - wake source from sleep or stop recorded, readable by host
// - sleep wake turns main regulator on; stop wake raises interrupt
// - wake-up input register shows live state of four wake inputs
// - direct wake: level sensitivity set, low-power config all zeros
// - sensitivity shared by inputs 0/1 and by inputs 2/3
// - cyclic sense pulses high-side switch, wakes on any input change
// - cyclic sense selected by setting bias and auto-cycle bits
// - forced wake-up refused while cyclic sense is enabled
// - direct or cyclic selection applies to all four inputs together
// - wake from sleep passes through reset before normal-request
// - stop wake gives short unmaskable interrupt pulse
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module reset_watchdog_wakeup_ctrl #(
  parameter int RST_CYC    = rwc_pkg::RST_DUR_CYC,
  parameter int PERIOD_CYC = rwc_pkg::CYC_PERIOD_DEF,
  parameter int ON_CYC     = rwc_pkg::CYC_ON_DEF
) (
  input  wire logic                      aclk,                     // clock
  input  wire logic                      aresetn,                  // sync reset, low
  input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_awaddr,            // write address
  input  wire logic                      s_axi_awvalid,            // write address valid
  output logic                           s_axi_awready,            // write address ready
  input  wire logic [31:0]               s_axi_wdata,              // write data
  input  wire logic [3:0]                s_axi_wstrb,              // write strobes
  input  wire logic                      s_axi_wvalid,             // write data valid
  output logic                           s_axi_wready,             // write data ready
  output logic [1:0]                     s_axi_bresp,              // write response
  output logic                           s_axi_bvalid,             // write response valid
  input  wire logic                      s_axi_bready,             // write response ready
  input  wire logic [rwc_pkg::ADDR_W-1:0] s_axi_araddr,            // read address
  input  wire logic                      s_axi_arvalid,            // read address valid
  output logic                           s_axi_arready,            // read address ready
  output logic [31:0]                    s_axi_rdata,              // read data
  output logic [1:0]                     s_axi_rresp,              // read response
  output logic                           s_axi_rvalid,             // read data valid
  input  wire logic                      s_axi_rready,             // read data ready
  input  wire logic [2:0]                op_mode,                  // operating mode code
  input  wire logic                      wd_timeout,               // watchdog expiry pulse
  input  wire logic                      wd_serviced,              // correct service pulse
  input  wire logic                      main_reg_low,             // undervoltage pin
  input  wire logic [3:0]                wake_inputs,              // wake input pins
  output logic                           reset_out_n,              // reset output, low
  output logic                           watchdog_fault_out_n,     // watchdog fault, low
  output logic                           int_out_n,                // interrupt, low
  output logic                           main_regulator_en,        // main regulator on
  output logic                           battery_high_side_switch, // switch drive
  output logic                           forced_wakeup_en,         // forced wake enable
  output logic                           wake_req                  // wake pulse to mode logic
);
  localparam int MAXC = (RST_CYC > rwc_pkg::INT_PULSE_CYC) ? RST_CYC : rwc_pkg::INT_PULSE_CYC;
  localparam int CW   = $clog2(MAXC + 1);
  localparam logic [CW-1:0] RST_LOAD = CW'(RST_CYC - 1);
  localparam logic [CW-1:0] INT_LOAD = CW'(rwc_pkg::INT_PULSE_CYC - 1);

  wake_if wk ();

  // pin synchronisers
  logic       uv_m_r, uv_s_r;
  logic [3:0] pin_m_r, pin_s_r;

  // bus state
  logic                      aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [rwc_pkg::ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]               wdata_r, wdata_nxt;
  logic                      wstrb0_r, wstrb0_nxt, wstrb1_r, wstrb1_nxt;
  logic                      awready_r, awready_nxt, wready_r, wready_nxt;
  logic                      bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic                      rvalid_r, rvalid_nxt;
  logic [1:0]                bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]               rdata_r, rdata_nxt;

  // register state
  logic       safe_r, safe_nxt;
  logic [1:0] sens_r, sens_nxt;
  logic [3:0] lpc_r, lpc_nxt;
  logic [3:0] src_r, src_nxt;

  // sequencer state
  rwc_pkg::phase_t phase_r, phase_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic            fault_r, fault_nxt;
  logic            rst_n_r, rst_n_nxt, int_n_r, int_n_nxt;
  logic            reg_en_r, reg_en_nxt, wake_req_r, wake_req_nxt;

  logic sleep, stop_any, debug, wd_live, wake_evt, do_write;

  assign sleep    = (op_mode == rwc_pkg::OP_SLEEP);
  assign stop_any = (op_mode == rwc_pkg::OP_STOP) || (op_mode == rwc_pkg::OP_STOP_DBG);
  assign debug    = (op_mode == rwc_pkg::OP_DBG_NORMAL) || (op_mode == rwc_pkg::OP_DBG_STDBY)
                    || (op_mode == rwc_pkg::OP_STOP_DBG);
  assign wd_live  = wd_timeout && !debug && !sleep;
  assign wake_evt = wk.wake && (sleep || stop_any);
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  assign wk.sens      = sens_r;
  assign wk.cyclic_en = lpc_r[rwc_pkg::LPC_BIAS_BIT] && lpc_r[rwc_pkg::LPC_AUTO_BIT];
  assign wk.low_power = sleep || stop_any;
  assign wk.pins      = pin_s_r;

  wake_sense #(
    .PERIOD_CYC (PERIOD_CYC),
    .ON_CYC     (ON_CYC)
  ) u_sense (
    .aclk    (aclk),
    .aresetn (aresetn),
    .w       (wk)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      uv_m_r  <= 1'b0;
      uv_s_r  <= 1'b0;
      pin_m_r <= 4'h0;
      pin_s_r <= 4'h0;
    end
    else
    begin
      uv_m_r  <= main_reg_low;
      uv_s_r  <= uv_m_r;
      pin_m_r <= wake_inputs;
      pin_s_r <= pin_m_r;
    end
  end

  // bus slave and registers
  always_comb
  begin
    aw_held_nxt = aw_held_r;
    w_held_nxt  = w_held_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    wstrb1_nxt  = wstrb1_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    safe_nxt    = safe_r;
    sens_nxt    = sens_r;
    lpc_nxt     = lpc_r;
    src_nxt     = src_r;
    if (s_axi_awvalid && awready_r)
    begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
      wstrb1_nxt = s_axi_wstrb[1];
    end
    if (s_axi_bready && bvalid_r)
      bvalid_nxt = 1'b0;
    if (do_write)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = rwc_pkg::RESP_OKAY;
      case (awaddr_r)
        rwc_pkg::ADDR_MODE_CTRL:
          if (wstrb0_r)
            safe_nxt = wdata_r[rwc_pkg::MCR_SAFE_BIT];
        rwc_pkg::ADDR_WAKE_IN:
        begin
          if (wstrb0_r)
            src_nxt = src_r & ~wdata_r[rwc_pkg::WUR_SRC_LSB +: 4];
          if (wstrb1_r || wstrb0_r)
            sens_nxt = wdata_r[rwc_pkg::WUR_SENS_LSB +: 2];
        end
        rwc_pkg::ADDR_LOW_POWER:
          if (wstrb0_r)
          begin
            lpc_nxt = wdata_r[3:0];
            if (wdata_r[rwc_pkg::LPC_BIAS_BIT] && wdata_r[rwc_pkg::LPC_AUTO_BIT])
              lpc_nxt[rwc_pkg::LPC_FWU_BIT] = 1'b0;
          end
        rwc_pkg::ADDR_STATUS:
          bresp_nxt = rwc_pkg::RESP_OKAY;
        default:
          bresp_nxt = rwc_pkg::RESP_SLVERR;
      endcase
    end
    if (wake_evt)
      src_nxt = src_nxt | wk.src;
    if (s_axi_rready && rvalid_r)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = rwc_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0;
      case (s_axi_araddr)
        rwc_pkg::ADDR_MODE_CTRL:
          rdata_nxt[rwc_pkg::MCR_SAFE_BIT] = safe_r;
        rwc_pkg::ADDR_WAKE_IN:
        begin
          rdata_nxt[rwc_pkg::WUR_PINS_LSB +: 4] = pin_s_r;
          rdata_nxt[rwc_pkg::WUR_SRC_LSB +: 4]  = src_r;
          rdata_nxt[rwc_pkg::WUR_SENS_LSB +: 2] = sens_r;
        end
        rwc_pkg::ADDR_LOW_POWER:
          rdata_nxt[3:0] = lpc_r;
        rwc_pkg::ADDR_STATUS:
        begin
          rdata_nxt[rwc_pkg::STAT_RST_BIT] = !rst_n_r;
          rdata_nxt[rwc_pkg::STAT_WDF_BIT] = fault_r;
          rdata_nxt[rwc_pkg::STAT_UV_BIT]  = uv_s_r;
        end
        default:
          rresp_nxt = rwc_pkg::RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt  = !w_held_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb0_r  <= 1'b0;
      wstrb1_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= rwc_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= rwc_pkg::RESP_OKAY;
      rdata_r   <= 32'h0;
      safe_r    <= rwc_pkg::SAFE_RST;
      sens_r    <= rwc_pkg::SENS_RST;
      lpc_r     <= rwc_pkg::LPC_RST;
      src_r     <= rwc_pkg::SRC_RST;
    end
    else
    begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      wstrb1_r  <= wstrb1_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      safe_r    <= safe_nxt;
      sens_r    <= sens_nxt;
      lpc_r     <= lpc_nxt;
      src_r     <= src_nxt;
    end
  end

  // reset, fault and interrupt sequencing
  always_comb
  begin
    phase_nxt    = phase_r;
    cnt_nxt      = cnt_r;
    fault_nxt    = wd_live || (fault_r && !wd_serviced);
    wake_req_nxt = wake_evt;
    case (phase_r)
      rwc_pkg::PH_IDLE:
        if ((wake_evt && sleep) || (wd_live && !safe_r))
        begin
          phase_nxt = rwc_pkg::PH_RESET;
          cnt_nxt   = RST_LOAD;
        end
        else if (wake_evt)
        begin
          phase_nxt = rwc_pkg::PH_INT;
          cnt_nxt   = INT_LOAD;
        end
      rwc_pkg::PH_RESET:
        if (cnt_r == '0)
          phase_nxt = rwc_pkg::PH_IDLE;
        else
          cnt_nxt = cnt_r - CW'(1);
      rwc_pkg::PH_INT:
        if ((cnt_r == '0) || sleep)
          phase_nxt = rwc_pkg::PH_IDLE;
        else
          cnt_nxt = cnt_r - CW'(1);
      default:
        phase_nxt = rwc_pkg::PH_IDLE;
    endcase
    rst_n_nxt  = !((phase_nxt == rwc_pkg::PH_RESET) || uv_s_r || sleep);
    int_n_nxt  = !(phase_nxt == rwc_pkg::PH_INT);
    reg_en_nxt = !sleep || (phase_nxt == rwc_pkg::PH_RESET);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_r    <= rwc_pkg::PH_RESET;
      cnt_r      <= RST_LOAD;
      fault_r    <= 1'b0;
      rst_n_r    <= 1'b0;
      int_n_r    <= 1'b1;
      reg_en_r   <= 1'b1;
      wake_req_r <= 1'b0;
    end
    else
    begin
      phase_r    <= phase_nxt;
      cnt_r      <= cnt_nxt;
      fault_r    <= fault_nxt;
      rst_n_r    <= rst_n_nxt;
      int_n_r    <= int_n_nxt;
      reg_en_r   <= reg_en_nxt;
      wake_req_r <= wake_req_nxt;
    end
  end

  assign s_axi_awready            = awready_r;
  assign s_axi_wready             = wready_r;
  assign s_axi_bvalid             = bvalid_r;
  assign s_axi_bresp              = bresp_r;
  assign s_axi_arready            = arready_r;
  assign s_axi_rvalid             = rvalid_r;
  assign s_axi_rresp              = rresp_r;
  assign s_axi_rdata              = rdata_r;
  assign reset_out_n              = rst_n_r;
  assign watchdog_fault_out_n     = !fault_r;
  assign int_out_n                = int_n_r;
  assign main_regulator_en        = reg_en_r;
  assign battery_high_side_switch = wk.hs_on;
  assign forced_wakeup_en         = lpc_r[rwc_pkg::LPC_FWU_BIT];
  assign wake_req                 = wake_req_r;
endmodule
`default_nettype wire

// >>> tb/rwc_properties.sv
// checker on the reset, watchdog-fault and wake ports
// assumes the design top module on one aclk domain
`timescale 1ns/1ps
`default_nettype none
module rwc_checker (
  input wire logic       aclk,                 // clock
  input wire logic       aresetn,              // reset, low
  input wire logic [2:0] op_mode,              // op mode
  input wire logic       wd_timeout,           // expiry
  input wire logic       wd_serviced,          // service
  input wire logic       main_reg_low,         // undervoltage
  input wire logic       reset_out_n,          // reset out
  input wire logic       watchdog_fault_out_n, // fault out
  input wire logic       int_out_n,            // interrupt
  input wire logic       main_regulator_en,    // regulator
  input wire logic       wake_req              // wake pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [10:0] low_r, low_nxt;
  // length of the current interrupt pulse
  always_comb low_nxt = int_out_n ? 11'h0 : low_r + 11'h1;
  always_ff @(posedge aclk) low_r <= aresetn ? low_nxt : 11'h0;
  property p_fault_set;
    wd_timeout && op_mode != rwc_pkg::OP_SLEEP && op_mode < rwc_pkg::OP_DBG_NORMAL
      |=> !watchdog_fault_out_n;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault not set");
  property p_fault_clr;
    wd_serviced && !wd_timeout |=> watchdog_fault_out_n;
  endproperty
  a_fault_clr: assert property (p_fault_clr)
    else $error("fault not released");
  property p_fault_hold;
    !watchdog_fault_out_n && !wd_serviced |=> !watchdog_fault_out_n;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault released early");
  property p_dbg;
    op_mode >= rwc_pkg::OP_DBG_NORMAL && watchdog_fault_out_n |=> watchdog_fault_out_n;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("fault in debug mode");
  property p_sleep;
    (op_mode == rwc_pkg::OP_SLEEP) [*2] |-> !reset_out_n && int_out_n;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep outputs wrong");
  property p_uv;
    main_reg_low [*4] |=> !reset_out_n;
  endproperty
  a_uv: assert property (p_uv)
    else $error("no reset on undervoltage");
  property p_stop_int;
    wake_req && reset_out_n && op_mode == rwc_pkg::OP_STOP |-> !int_out_n;
  endproperty
  a_stop_int: assert property (p_stop_int)
    else $error("no interrupt on stop wake");
  property p_int_len;
    $rose(int_out_n) |-> low_r == 11'(rwc_pkg::INT_PULSE_CYC);
  endproperty
  a_int_len: assert property (p_int_len)
    else $error("interrupt pulse length wrong");
  property p_sleep_wake;
    wake_req && op_mode == rwc_pkg::OP_SLEEP |=> main_regulator_en && !reset_out_n;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep wake outputs wrong");
  c_stop: cover property (wake_req && op_mode == rwc_pkg::OP_STOP);
  c_sleep: cover property (wake_req && op_mode == rwc_pkg::OP_SLEEP);
  c_fault: cover property ($rose(watchdog_fault_out_n));
endmodule
bind reset_watchdog_wakeup_ctrl rwc_checker chk (.aclk, .aresetn, .op_mode, .wd_timeout,
  .wd_serviced, .main_reg_low, .reset_out_n, .watchdog_fault_out_n, .int_out_n,
  .main_regulator_en, .wake_req);
`default_nettype wire

// >>> tb/axi_host.sv
// host model: AXI4-Lite master tasks for register access
// assumes one aclk and a testbench top with a hang task
`timescale 1ns/1ps
`default_nettype none
module axi_host (
  input  wire logic        aclk,          // clock
  output logic [7:0]       s_axi_awaddr,  // aw addr
  output logic             s_axi_awvalid, // aw valid
  input  wire logic        s_axi_awready, // aw ready
  output logic [31:0]      s_axi_wdata,   // w data
  output logic [3:0]       s_axi_wstrb,   // w strobes
  output logic             s_axi_wvalid,  // w valid
  input  wire logic        s_axi_wready,  // w ready
  input  wire logic [1:0]  s_axi_bresp,   // b resp
  input  wire logic        s_axi_bvalid,  // b valid
  output logic             s_axi_bready,  // b ready
  output logic [7:0]       s_axi_araddr,  // ar addr
  output logic             s_axi_arvalid, // ar valid
  input  wire logic        s_axi_arready, // ar ready
  input  wire logic [31:0] s_axi_rdata,   // r data
  input  wire logic [1:0]  s_axi_rresp,   // r resp
  input  wire logic        s_axi_rvalid,  // r valid
  output logic             s_axi_rready   // r ready
);
  initial {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
  initial {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {48'h0, 4'hf};
  // released payload toggles so stale values cannot match
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~s_axi_awaddr};
      if (s_axi_wready)
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 50)
      testbench.hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~s_axi_araddr};
    end
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    if (n == 50)
      testbench.hang();
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the reset, watchdog and wake-up control block
// assumes the host model and the checker bound to the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int RST = 20;
  typedef struct {logic [7:0] a; logic [31:0] d, m, e; logic [1:0] rs;} row_t;
  row_t rows [8] = '{
    '{8'h08, 32'h9, 32'hf, 32'h9, 2'h0},
    '{8'h08, 32'hb, 32'hf, 32'h9, 2'h0},
    '{8'h08, 32'h2, 32'hf, 32'h2, 2'h0},
    '{8'h08, 32'h0, 32'hf, 32'h0, 2'h0},
    '{8'h04, 32'h2f0, 32'h300, 32'h200, 2'h0},
    '{8'h00, 32'h1, 32'h1, 32'h1, 2'h0},
    '{8'h10, 32'h1, 32'hffffffff, 32'h0, 2'h2},
    '{8'h00, 32'h0, 32'h1, 32'h0, 2'h0}};
  logic aclk, aresetn, wd_timeout, wd_serviced, main_reg_low;
  logic [2:0] op_mode;
  logic [3:0] wake_inputs, s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic reset_out_n, watchdog_fault_out_n, int_out_n, main_regulator_en;
  logic battery_high_side_switch, forced_wakeup_en, wake_req;
  int failures = 0;
  int cmp_count = 0;
  int i;
  reset_watchdog_wakeup_ctrl #(.RST_CYC(RST), .PERIOD_CYC(40), .ON_CYC(4)) dut (.*);
  axi_host h (.*);
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic hang();
    failures++;
    results();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wd(logic t, logic s);
    {wd_timeout, wd_serviced} <= {t, s};
    cyc(1);
    {wd_timeout, wd_serviced} <= 2'h0;
    cyc(1);
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, wd_timeout, wd_serviced, main_reg_low, wake_inputs} = 8'h0;
    op_mode = rwc_pkg::OP_NORMAL;
    cyc(8);
    aresetn <= 1'b1;
    cyc(2);
    chk("rst", 0, reset_out_n);
    chk("fault", 1, watchdog_fault_out_n);
    cyc(RST + 5);
    chk("rst", 1, reset_out_n);
    h.rd(8'h00, rd, rs);
    chk("safe", 0, rd & 32'h1);
    foreach (rows[k])
    begin
      h.wr(rows[k].a, rows[k].d, rs);
      chk("bresp", rows[k].rs, rs);
      h.rd(rows[k].a, rd, rs);
      chk("rresp", rows[k].rs, rs);
      chk("rdata", rows[k].e, rd & rows[k].m);
      chk("fwu", rows[k].e[1] && rows[k].a == 8'h08, forced_wakeup_en);
    end
    wd(1, 0);
    chk("fault", 0, watchdog_fault_out_n);
    chk("rst", 0, reset_out_n);
    cyc(RST + 5);
    chk("fault", 0, watchdog_fault_out_n);
    wd(0, 1);
    chk("fault", 1, watchdog_fault_out_n);
    h.wr(8'h00, 32'h1, rs);
    op_mode <= rwc_pkg::OP_STANDBY;
    wd(1, 0);
    chk("rst", 1, reset_out_n);
    chk("fault", 0, watchdog_fault_out_n);
    h.rd(8'h00, rd, rs);
    chk("safe", 1, rd & 32'h1);
    wd(1, 1);
    chk("fault", 0, watchdog_fault_out_n);
    wd(0, 1);
    chk("fault", 1, watchdog_fault_out_n);
    h.wr(8'h00, 32'h0, rs);
    op_mode <= rwc_pkg::OP_DBG_NORMAL;
    wd(1, 0);
    chk("fault", 1, watchdog_fault_out_n);
    main_reg_low <= 1'b1;
    cyc(6);
    chk("rst", 0, reset_out_n);
    main_reg_low <= 1'b0;
    wake_inputs <= 4'ha;
    cyc(RST + 10);
    h.rd(8'h04, rd, rs);
    chk("pins", 32'ha, rd & 32'hf);
    wake_inputs <= 4'h0;
    h.wr(8'h04, 32'h3f0, rs);
    h.wr(8'h08, 32'h0, rs);
    op_mode <= rwc_pkg::OP_STOP;
    cyc(4);
    wake_inputs <= 4'h2;
    for (i = 0; i < 20 && wake_req !== 1'b1; i++)
      @(posedge aclk);
    chk("int", 0, int_out_n);
    op_mode <= rwc_pkg::OP_NORMAL_REQ;
    h.rd(8'h04, rd, rs);
    chk("src", 32'h2, (rd >> 4) & 32'hf);
    for (i = 0; i < 1100 && int_out_n !== 1'b1; i++)
      @(posedge aclk);
    chk("int", 1, int_out_n);
    h.wr(8'h04, 32'h0f0, rs);
    h.wr(8'h08, 32'h9, rs);
    {op_mode, wake_inputs} <= {rwc_pkg::OP_SLEEP, 4'h0};
    cyc(3);
    chk("reg", 0, main_regulator_en);
    for (i = 0; i < 100 && battery_high_side_switch !== 1'b1; i++)
      @(posedge aclk);
    chk("switch", 1, battery_high_side_switch);
    cyc(45);
    wake_inputs <= 4'h8;
    for (i = 0; i < 100 && wake_req !== 1'b1; i++)
      @(posedge aclk);
    cyc(1);
    chk("reg", 1, main_regulator_en);
    chk("rst", 0, reset_out_n);
    op_mode <= rwc_pkg::OP_NORMAL_REQ;
    h.rd(8'h04, rd, rs);
    chk("src", 32'h8, (rd >> 4) & 32'hf);
    results();
  end
endmodule
`default_nettype wire
